// File: pkg/ccd_afe_params.svh
// Constants for the CCD front end output and black clamp block
`ifndef CCD_AFE_PARAMS_SVH
`define CCD_AFE_PARAMS_SVH
`define DUMMY_CLAMP_CONTROL_ADDR 8'hf7
`define DUMMY_CLAMP_CONTROL_RESET 16'h0000
`define OFFSET_MSB 12
`define OFFSET_LSB 10
`define LOOP_GAIN_MSB 9
`define LOOP_GAIN_LSB 8
`define LATENCY_CORRELATED 10
`define LATENCY_DIRECT 9
`define OB_WINDOW_FIRST 5
`define OB_WINDOW_LAST 12
`define OB_COUNT_MAX 4'hf
`define PREBLANK_CLAMP_CODE 10'h04c
`define BLACK_OUT_OF_RANGE 10'h0c8
`define PIPE_DEPTH 10
`endif

// File: pkg/ccd_afe_pkg.sv
// Types for the CCD front end output and black clamp block
package ccd_afe_pkg;
	typedef logic [9:0] pixel_t;
	typedef enum logic [1:0] {
		CLAMP_OB = 2'b01,
		CLAMP_DUMMY = 2'b10
	} clamp_state_t;
endpackage

// File: logic/ccd_output_clamp.sv
// Pixel output pipeline, black window averaging and dummy clamp control
`timescale 1ns/10ps
`include "ccd_afe_params.svh"

// How it works
// - Pixel bus updates on conversion clock rising edge
// - Latency ten correlated, nine direct mode
// - Direct mode samples input every rising edge
// - Cycles five to twelve after pulse form window
// - Eight window samples averaged into clamp level
// - Register F7 bits 12:10 pick dummy offset
// - Out-of-range black switches to dummy clamping
// - Dummy offset scales with amplifier gain
// - Bits 9:8 cut loop gain, dummy only
// - Four-bit sample/hold time constant select
// - Bandwidth select plus low power picks cutoff
// - Preblank forces output to clamp code
// - Invert low nine and top bit options
module ccd_output_clamp
	import ccd_afe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Converter side
	input wire logic correlated_input_mode,
	input wire logic [9:0] conv_sample,
	input wire logic [2:0] pga_gain_shift,
	// Pins
	input wire logic optical_black_pulse,
	input wire logic preblank_input,
	// Output setup
	input wire logic low_bits_invert,
	input wire logic top_bit_invert,
	input wire logic gray_code_select,
	input wire logic low_power_sel,
	input wire logic [3:0] black_sh_time_const_sel,
	input wire logic [1:0] sha_bandwidth_sel,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	output logic [15:0] reg_rdata,
	// Outputs
	output logic [9:0] pixel_out,
	output logic [9:0] clamp_level,
	output logic clamp_dummy_active,
	output logic [2:0] loop_gain_shift,
	output logic [3:0] sh_time_const,
	output logic [2:0] sha_cutoff_code
);
	logic [15:0] ctrl_reg, ctrl_next;
	logic [1:0] obp_sync_reg, preblank_input_sync_reg;
	logic obp_prev_reg;
	logic [3:0] ob_cnt_reg, ob_cnt_next;
	logic [12:0] ob_sum_reg, ob_sum_next;
	pixel_t ob_avg_reg, ob_avg_next;
	clamp_state_t state_reg, state_next;
	pixel_t pipe_reg [0:`PIPE_DEPTH-1];
	pixel_t pipe_next [0:`PIPE_DEPTH-1];
	pixel_t pix_reg, pix_next;
	pixel_t clamp_reg, clamp_next;
	logic [9:0] dummy_off;
	logic [11:0] clamp_sum;
	pixel_t tapped, coded;
	logic obp_rise, in_window;

	// Register write and readback
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (reg_write && reg_addr == `DUMMY_CLAMP_CONTROL_ADDR)
			ctrl_next = reg_wdata;
	end

	// Window timing, restarted by every synchronised pulse rising edge
	assign obp_rise = obp_sync_reg[1] && !obp_prev_reg;
	assign in_window = ob_cnt_reg >= 4'(`OB_WINDOW_FIRST) &&
		ob_cnt_reg <= 4'(`OB_WINDOW_LAST);

	always_comb
	begin
		ob_cnt_next = ob_cnt_reg;
		ob_sum_next = ob_sum_reg;
		ob_avg_next = ob_avg_reg;
		state_next = state_reg;
		if (obp_rise)
		begin
			ob_cnt_next = 4'h1;
			ob_sum_next = 13'h0000;
		end
		else if (ob_cnt_reg != 4'h0 && ob_cnt_reg != `OB_COUNT_MAX)
			ob_cnt_next = ob_cnt_reg + 4'h1;
		if (!obp_rise && in_window)
			ob_sum_next = ob_sum_reg + {3'h0, conv_sample};
		if (!obp_rise && ob_cnt_reg == 4'(`OB_WINDOW_LAST))
		begin
			ob_avg_next = ob_sum_next[12:3];
			// Highlight pushes black high; fall back to dummy bit level
			if (ob_sum_next[12:3] > `BLACK_OUT_OF_RANGE)
				state_next = CLAMP_DUMMY;
			else
				state_next = CLAMP_OB;
		end
	end

	// Dummy offset, scaled down as the amplifier gain rises
	always_comb
	begin
		case (ctrl_reg[`OFFSET_MSB:`OFFSET_LSB])
			3'h1: dummy_off = 10'h020;
			3'h2: dummy_off = 10'h040;
			3'h3: dummy_off = 10'h060;
			3'h7: dummy_off = 10'h0e0;
			default: dummy_off = 10'h000;
		endcase
		dummy_off = dummy_off >> pga_gain_shift;
	end

	assign clamp_sum = {2'h0, ob_avg_reg} + {2'h0, dummy_off};

	always_comb
	begin
		case (state_reg)
			CLAMP_DUMMY: clamp_next = (clamp_sum > 12'h3ff) ? 10'h3ff : clamp_sum[9:0];
			default: clamp_next = ob_avg_reg;
		endcase
	end

	// Conversion pipeline; tap picks the mode's latency
	always_comb
	begin
		pipe_next[0] = conv_sample;
		for (int i = 1; i < `PIPE_DEPTH; i++)
			pipe_next[i] = pipe_reg[i-1];
	end

	// Tap index is latency minus the output register
	assign tapped = correlated_input_mode ? pipe_reg[`LATENCY_CORRELATED-1] :
		pipe_reg[`LATENCY_DIRECT-1];

	always_comb
	begin
		coded = gray_code_select ? (tapped ^ (tapped >> 1)) : tapped;
		coded[8:0] = low_bits_invert ? ~coded[8:0] : coded[8:0];
		coded[9] = top_bit_invert ? ~coded[9] : coded[9];
		pix_next = preblank_input_sync_reg[1] ? `PREBLANK_CLAMP_CODE : coded;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ctrl_reg <= `DUMMY_CLAMP_CONTROL_RESET;
			obp_sync_reg <= 2'h0;
			preblank_input_sync_reg <= 2'h0;
			obp_prev_reg <= 1'b0;
			ob_cnt_reg <= 4'h0;
			ob_sum_reg <= 13'h0000;
			ob_avg_reg <= 10'h000;
			state_reg <= CLAMP_OB;
			clamp_reg <= 10'h000;
			pix_reg <= 10'h000;
			for (int i = 0; i < `PIPE_DEPTH; i++)
				pipe_reg[i] <= 10'h000;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			obp_sync_reg <= {obp_sync_reg[0], optical_black_pulse};
			preblank_input_sync_reg <= {preblank_input_sync_reg[0], preblank_input};
			obp_prev_reg <= obp_sync_reg[1];
			ob_cnt_reg <= ob_cnt_next;
			ob_sum_reg <= ob_sum_next;
			ob_avg_reg <= ob_avg_next;
			state_reg <= state_next;
			clamp_reg <= clamp_next;
			pix_reg <= pix_next;
			for (int i = 0; i < `PIPE_DEPTH; i++)
				pipe_reg[i] <= pipe_next[i];
		end
	end

	// Registered setting outputs
	logic [15:0] rdata_reg, rdata_next;
	logic [2:0] lg_reg, lg_next, cut_reg, cut_next;
	logic [3:0] sh_reg, sh_next;
	logic dummy_reg, dummy_next;

	always_comb
	begin
		rdata_next = (reg_addr == `DUMMY_CLAMP_CONTROL_ADDR) ? ctrl_reg : 16'h0000;
		// Shift 2..5 is 1/4..1/32; zero outside dummy clamping
		lg_next = (state_next == CLAMP_DUMMY) ?
			3'h2 + {1'b0, ctrl_reg[`LOOP_GAIN_MSB:`LOOP_GAIN_LSB]} : 3'h0;
		sh_next = black_sh_time_const_sel;
		cut_next = {low_power_sel, sha_bandwidth_sel};
		// Own flop so the status pin has no decode glitch
		dummy_next = (state_next == CLAMP_DUMMY);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rdata_reg <= 16'h0000;
			lg_reg <= 3'h0;
			sh_reg <= 4'h0;
			cut_reg <= 3'h0;
			dummy_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			lg_reg <= lg_next;
			sh_reg <= sh_next;
			cut_reg <= cut_next;
			dummy_reg <= dummy_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign pixel_out = pix_reg;
	assign clamp_level = clamp_reg;
	assign clamp_dummy_active = dummy_reg;
	assign loop_gain_shift = lg_reg;
	assign sh_time_const = sh_reg;
	assign sha_cutoff_code = cut_reg;
endmodule

// File: dv/pixel_sink.sv
// Camera processor side model taking each pixel word
`timescale 1ns/10ps
module pixel_sink (
	// Clock
	input wire logic clk,
	// Pixel bus
	input wire logic [9:0] pixel_out,
	output logic [9:0] word
);
	// Taken on rising edge, like the real processor
	always_ff @(posedge clk) word <= pixel_out;
endmodule

// File: dv/ccd_oc_checker.sv
// Assertions for the output and clamp block
`timescale 1ns/10ps
module ccd_oc_checker (
	input wire logic clk, rst_b, correlated_input_mode, preblank_input, reg_write,
	input wire logic gray_code_select, low_bits_invert, top_bit_invert, clamp_dummy_active,
	input wire logic low_power_sel,
	input wire logic [9:0] conv_sample, pixel_out,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata, reg_rdata,
	input wire logic [2:0] loop_gain_shift, sha_cutoff_code,
	input wire logic [3:0] black_sh_time_const_sel, sh_time_const,
	input wire logic [1:0] sha_bandwidth_sel
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Cycles of plain coding in one mode; pipeline must flush first
	logic [3:0] calm;
	always_ff @(posedge clk)
		calm <= (!rst_b || preblank_input || gray_code_select || low_bits_invert
			|| top_bit_invert || $changed(correlated_input_mode)) ? 4'h0
			: calm + {3'h0, calm != 4'hf};
	sequence s_pb; preblank_input[*3]; endsequence
	sequence s_wr; reg_write && reg_addr == 8'hf7 ##1 reg_addr == 8'hf7; endsequence
	property p_lat; calm == 4'hf && correlated_input_mode |-> pixel_out == $past(conv_sample, 11);
	endproperty
	property p_dir; calm == 4'hf && !correlated_input_mode |-> pixel_out == $past(conv_sample, 10);
	endproperty
	property p_pb; s_pb |=> pixel_out == 10'h04c; endproperty
	property p_lg; $stable(clamp_dummy_active) |-> (clamp_dummy_active ?
		loop_gain_shift inside {[3'h2:3'h5]} : loop_gain_shift == 3'h0); endproperty
	property p_sh; $past(rst_b) && $stable(black_sh_time_const_sel) |->
		sh_time_const == black_sh_time_const_sel; endproperty
	property p_bw; $past(rst_b) && $stable({low_power_sel, sha_bandwidth_sel}) |->
		sha_cutoff_code == {low_power_sel, sha_bandwidth_sel}; endproperty
	property p_rd0; reg_addr != 8'hf7 |=> reg_rdata == 16'h0000; endproperty
	property p_wr; s_wr |=> reg_rdata[12:8] == $past(reg_wdata[12:8], 2); endproperty
	a_lat: assert property (p_lat) else $error("correlated latency wrong");
	a_dir: assert property (p_dir) else $error("direct latency wrong");
	a_pb: assert property (p_pb) else $error("preblank code missing");
	a_lg: assert property (p_lg) else $error("loop gain wrong");
	a_sh: assert property (p_sh) else $error("time constant wrong");
	a_bw: assert property (p_bw) else $error("cutoff wrong");
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	a_wr: assert property (p_wr) else $error("readback wrong");
endmodule
bind ccd_output_clamp ccd_oc_checker chk (.*);

// File: dv/ccd_output_clamp_tb_top.sv
// Self-checking bench for the output and clamp block
`timescale 1ns/10ps
module ccd_output_clamp_tb_top;
	import ccd_afe_pkg::*;
	logic clk = 0, rst_b = 0, correlated_input_mode = 1, optical_black_pulse = 0;
	logic preblank_input = 0, low_bits_invert = 0, top_bit_invert = 0, gray_code_select = 0;
	logic low_power_sel = 1, reg_write = 0, hold = 0, clamp_dummy_active;
	pixel_t conv_sample = 0, lvl = 0, pixel_out, clamp_level, word, v;
	logic [2:0] pga_gain_shift = 3'h1, loop_gain_shift, sha_cutoff_code;
	logic [3:0] black_sh_time_const_sel = 4'ha, sh_time_const;
	logic [1:0] sha_bandwidth_sel = 2'h3;
	logic [7:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	int errors = 0, num_checks = 0, cyc = 0;
	ccd_output_clamp DUT (.*);
	pixel_sink sink (.clk, .pixel_out, .word);
	always #50 clk = ~clk;
	// Ramp input makes every word tell its own age
	always @(negedge clk)
	begin
		cyc <= cyc + 1;
		conv_sample <= hold ? lvl : cyc[9:0];
		if (cyc == 3000)
		begin
			errors++;
			test_done;
		end
	end
	task chk(input logic [15:0] s, e);
		num_checks++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [15:0] d, e);
		@(negedge clk) reg_addr = a;
		reg_wdata = d;
		reg_write = w;
		@(negedge clk) reg_write = 0;
		@(negedge clk) chk(reg_rdata, e);
	endtask
	task pix(input int lat);
		repeat (16) @(negedge clk);
		v = 10'(cyc - lat - 2);
		v = gray_code_select ? v ^ (v >> 1) : v;
		chk(word, v ^ {top_bit_invert, {9{low_bits_invert}}});
	endtask
	task ob(input pixel_t l, c, input logic d, input logic [2:0] g);
		// Off-window samples differ, so a shifted window shows up
		lvl <= ~l;
		repeat (14) @(negedge clk);
		optical_black_pulse = 1;
		@(negedge clk) optical_black_pulse = 0;
		repeat (5) @(negedge clk);
		lvl <= l;
		repeat (8) @(negedge clk);
		lvl <= ~l;
		repeat (7) @(negedge clk);
		chk(clamp_level, c);
		chk(clamp_dummy_active, d);
		chk(loop_gain_shift, g);
	endtask
	task test_done;
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		rst_b = 1;
		acc(0, 8'hf7, 0, 0);
		acc(1, 8'hf7, 16'h1f00, 16'h1f00);
		acc(1, 8'h10, 16'h00ff, 0);
		acc(0, 8'hf7, 0, 16'h1f00);
		for (int i = 0; i < 8; i++)
		begin
			{gray_code_select, top_bit_invert, low_bits_invert} = i[2:0];
			pix(10);
		end
		{gray_code_select, top_bit_invert, low_bits_invert} = 3'h0;
		correlated_input_mode = 0;
		pix(9);
		preblank_input = 1;
		repeat (4) @(negedge clk);
		chk(word, 10'h04c);
		preblank_input = 0;
		hold = 1;
		ob(10'h100, 10'h170, 1, 3'h5);
		pga_gain_shift = 3'h0;
		ob(10'h100, 10'h1e0, 1, 3'h5);
		ob(10'h064, 10'h064, 0, 3'h0);
		acc(1, 8'hf7, 16'h0900, 16'h0900);
		ob(10'h100, 10'h140, 1, 3'h3);
		chk(sh_time_const, 4'ha);
		chk(sha_cutoff_code, 3'h7);
		test_done;
	end
endmodule
